// ### src/ccet_defs.svh
// Register offsets, field positions, reset values and event flag positions of the calendar clock
`ifndef CCET_DEFS_SVH
`define CCET_DEFS_SVH
// Register byte offsets
`define CCET_CTRL 8'h00
`define CCET_HOUR_MODE 8'h04
`define CCET_TIME 8'h08
`define CCET_CAL 8'h0C
`define CCET_ALM_TIME 8'h10
`define CCET_ALM_CAL 8'h14
`define CCET_ALM_EN 8'h18
`define CCET_INT_EN 8'h1C
`define CCET_INT_DIS 8'h20
`define CCET_FLAGS 8'h24
`define CCET_FLAG_EN 8'h28
`define CCET_KEEP 8'h2C
`define CCET_TICK_DIV 8'h30
`define CCET_DENOM 8'h34
`define CCET_WAKE_PER 8'h38
`define CCET_WAKE_CTRL 8'h3C
`define CCET_WAKE_CLR 8'h40
`define CCET_WAKE_CNT 8'h44
// Field positions
`define CCET_SEC_LSB 8
`define CCET_MIN_LSB 16
`define CCET_HOUR_LSB 24
`define CCET_PM_BIT 30
`define CCET_DATE_LSB 8
`define CCET_MONTH_LSB 16
`define CCET_YEAR_LSB 20
`define CCET_CENT_LSB 27
`define CCET_FRAC_LSB 16
`define CCET_DIV_EN_BIT 31
`define CCET_RECUR_BIT 6
// Reset values
`define CCET_CTRL_RST 2'h3
`define CCET_DIV_INT_RST 10'h147
`define CCET_DIV_FRAC_RST 10'h2A8
`define CCET_DENOM_RST 10'h3E8
`define CCET_WAKE_PER_RST 13'h0064
`define CCET_CENT_RST 5'h14
// Event flag positions: sec, min, hour, half day, day, week, month, alarm
`define CCET_EV_ALARM 7
`endif

// ### src/ccet_pkg.sv
// Types shared by the calendar clock
package ccet_pkg;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [6:0] hsec;
  } ccet_time_type;
  typedef struct packed {
    logic [4:0] century;
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] date;
    logic [2:0] dow;
  } ccet_cal_type;
endpackage

// ### src/ccet_top.sv
// Calendar clock with alarms, rollover events and periodic wake counter
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ccet_defs.svh"
module ccet_top #(
  parameter int WAKE_W = 13
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sw_reset_i,
  // Low-power clock pin
  input wire logic lp_clk_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Event outputs
  output logic rtc_irq_o,
  output logic wake_o,
  output logic wake_irq_o
);
  if (WAKE_W < 2 || WAKE_W > 16)
  begin : g_chk
    $error("WAKE_W must lie in 2..16");
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  // Month length, leap rule and 12-hour conversion
  function automatic logic is_leap(input logic [4:0] c, input logic [6:0] y);
    is_leap = (y == 7'h00) ? (c[1:0] == 2'h0) : (y[1:0] == 2'h0);
  endfunction
  function automatic logic [4:0] days_in(input logic [3:0] m, input logic lp);
    case (m)
      4'h2: days_in = lp ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
      default: days_in = 5'h1F;
    endcase
  endfunction
  function automatic logic [4:0] from12(input logic [4:0] h, input logic pm);
    if (h == 5'h0C)
      from12 = pm ? 5'h0C : 5'h00;
    else
      from12 = pm ? h + 5'h0C : h;
  endfunction
  function automatic logic [4:0] to12(input logic [4:0] h);
    if (h == 5'h00)
      to12 = 5'h0C;
    else
      to12 = (h > 5'h0C) ? h - 5'h0C : h;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ccet_pkg::ccet_time_type tm, alm_t, next_tm;
  ccet_pkg::ccet_cal_type cal, alm_c, next_cal;
  logic time_dis, cal_dis, hour12, keep, div_en, recur, chk, tick, extra;
  logic [5:0] alm_en;
  logic [7:0] int_mask, flag_en, flags;
  logic [9:0] div_int, div_frac, div_den, lp_cnt, frac_acc;
  logic [WAKE_W-1:0] wake_per, wake_cnt;
  logic wake_en;
  logic lp_m, lp_s, lp_d;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i & pready_o;
  wire wr = acc & pwrite_i & ~pslverr_o & ~sw_reset_i; // Writes ignored in software reset
  wire rd = acc & ~pwrite_i;
  // Address is an argument so every assign using it re-evaluates when it changes
  function automatic logic at(input logic [7:0] p, input logic [7:0] a);
    at = (p == a);
  endfunction
  wire known = at(paddr_i, `CCET_CTRL) | at(paddr_i, `CCET_HOUR_MODE)
    | at(paddr_i, `CCET_TIME) | at(paddr_i, `CCET_CAL) | at(paddr_i, `CCET_ALM_TIME)
    | at(paddr_i, `CCET_ALM_CAL) | at(paddr_i, `CCET_ALM_EN) | at(paddr_i, `CCET_INT_EN)
    | at(paddr_i, `CCET_INT_DIS) | at(paddr_i, `CCET_FLAGS) | at(paddr_i, `CCET_FLAG_EN)
    | at(paddr_i, `CCET_KEEP) | at(paddr_i, `CCET_TICK_DIV) | at(paddr_i, `CCET_DENOM)
    | at(paddr_i, `CCET_WAKE_PER) | at(paddr_i, `CCET_WAKE_CTRL)
    | at(paddr_i, `CCET_WAKE_CLR) | at(paddr_i, `CCET_WAKE_CNT);

  // Write word as seen in the current hour format
  wire [4:0] w_hr_raw = pwdata_i[`CCET_HOUR_LSB+:5];
  wire w_pm = pwdata_i[`CCET_PM_BIT];
  wire [4:0] w_hr = hour12 ? from12(w_hr_raw, w_pm) : w_hr_raw;
  wire ccet_pkg::ccet_time_type w_tm = {w_hr, pwdata_i[`CCET_MIN_LSB+:6],
    pwdata_i[`CCET_SEC_LSB+:6], pwdata_i[6:0]};
  wire ccet_pkg::ccet_cal_type w_cal = {pwdata_i[`CCET_CENT_LSB+:5],
    pwdata_i[`CCET_YEAR_LSB+:7], pwdata_i[`CCET_MONTH_LSB+:4],
    pwdata_i[`CCET_DATE_LSB+:5], pwdata_i[2:0]};
  // Out-of-range writes to the time, alarm time or calendar register are refused whole with pslverr
  wire hr_ok = hour12 ? (w_hr_raw != 5'h00 && w_hr_raw <= 5'h0C) : (w_hr_raw <= 5'h17);
  wire tm_ok = hr_ok && w_tm.min <= 6'h3B && w_tm.sec <= 6'h3B && w_tm.hsec <= 7'h63;
  wire mo_ok = w_cal.month != 4'h0 && w_cal.month <= 4'hC;
  wire cal_ok = mo_ok && w_cal.dow != 3'h0 && w_cal.date != 5'h00
    && w_cal.date <= days_in(w_cal.month, is_leap(w_cal.century, w_cal.year))
    && w_cal.year <= 7'h63 && w_cal.century >= 5'h13 && w_cal.century <= 5'h1D;
  wire bad_wr = ((at(paddr_i, `CCET_TIME) | at(paddr_i, `CCET_ALM_TIME)) & ~tm_ok)
    | (at(paddr_i, `CCET_CAL) & ~cal_ok);

  wire wr_time = wr & at(paddr_i, `CCET_TIME);
  wire wr_cal = wr & at(paddr_i, `CCET_CAL);
  wire rd_wclr = rd & at(paddr_i, `CCET_WAKE_CLR);
  wire [7:0] flag_clr = (rd & at(paddr_i, `CCET_FLAGS)) ? prdata_o[7:0] : 8'h00;

  // Read mux, hour shown in the selected format
  logic [31:0] rd_mux;
  wire [4:0] r_hr = hour12 ? to12(tm.hour) : tm.hour;
  wire [4:0] ra_hr = hour12 ? to12(alm_t.hour) : alm_t.hour;
  wire r_pm = hour12 & (tm.hour >= 5'h0C);
  wire ra_pm = hour12 & (alm_t.hour >= 5'h0C);
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `CCET_CTRL: rd_mux = {30'h0, cal_dis, time_dis};
      `CCET_HOUR_MODE: rd_mux = {31'h0, hour12};
      `CCET_TIME: rd_mux = {1'b0, r_pm, 1'b0, r_hr, 2'h0, tm.min, 2'h0, tm.sec, 1'b0, tm.hsec};
      `CCET_CAL: rd_mux = {cal.century, cal.year, cal.month, 3'h0, cal.date, 5'h0, cal.dow};
      `CCET_ALM_TIME: rd_mux = {1'b0, ra_pm, 1'b0, ra_hr, 2'h0, alm_t.min, 2'h0,
        alm_t.sec, 1'b0, alm_t.hsec};
      `CCET_ALM_CAL: rd_mux = {12'h0, alm_c.month, 3'h0, alm_c.date, 8'h0};
      `CCET_ALM_EN: rd_mux = {25'h0, recur, alm_en};
      `CCET_INT_EN: rd_mux = {24'h0, int_mask};
      `CCET_FLAGS: rd_mux = {24'h0, flags};
      `CCET_FLAG_EN: rd_mux = {24'h0, flag_en};
      `CCET_KEEP: rd_mux = {31'h0, keep};
      `CCET_TICK_DIV: rd_mux = {div_en, 5'h0, div_frac, 6'h0, div_int};
      `CCET_DENOM: rd_mux = {22'h0, div_den};
      `CCET_WAKE_PER: rd_mux = 32'(wake_per);
      `CCET_WAKE_CTRL: rd_mux = {31'h0, wake_en};
      `CCET_WAKE_CNT: rd_mux = 32'(wake_cnt);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after setup: pready rises in the access phase
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= setup;
      pslverr_o <= setup & (~known | (pwrite_i & bad_wr));
      prdata_o <= (setup & ~pwrite_i & known) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Tick divider
  // ----------------------------------------
  // Low-power clock is a foreign pin: two flops before any use
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {lp_m, lp_s, lp_d} <= 3'h0;
    else
      {lp_m, lp_s, lp_d} <= {lp_clk_i, lp_m, lp_s};
  end
  // Period is int or int+1 edges; fraction accumulates against denominator
  wire lp_rise = lp_s & ~lp_d;
  wire [10:0] frac_sum = {1'b0, frac_acc} + {1'b0, div_frac};
  wire frac_wrap = frac_sum >= {1'b0, div_den};
  wire [10:0] lim = {1'b0, div_int} + {10'h000, extra};
  wire period_end = lp_rise & ({1'b0, lp_cnt} + 11'h001 >= lim);
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {lp_cnt, frac_acc, extra, tick} <= 22'h0;
    else if (!div_en)
      {lp_cnt, frac_acc, extra, tick} <= 22'h0;
    else
    begin
      tick <= period_end;
      if (period_end)
      begin
        lp_cnt <= 10'h000;
        frac_acc <= frac_wrap ? 10'(frac_sum - {1'b0, div_den}) : frac_sum[9:0];
        extra <= frac_wrap;
      end
      else if (lp_rise)
        lp_cnt <= lp_cnt + 10'h001;
    end
  end
  tick_pulse_a: assert property (tick |=> !tick) else $error("tick not single");

  // ----------------------------------------
  // Time and calendar counting
  // ----------------------------------------
  wire t_run = tick & ~time_dis;
  wire hs_w = tm.hsec == 7'h63;
  wire s_w = hs_w & (tm.sec == 6'h3B);
  wire m_w = s_w & (tm.min == 6'h3B);
  wire h_w = m_w & (tm.hour == 5'h17);
  wire half_w = m_w & (tm.hour == 5'h0B);
  wire c_run = t_run & h_w & ~cal_dis;
  wire d_w = cal.date == days_in(cal.month, is_leap(cal.century, cal.year));
  wire mo_w = d_w & (cal.month == 4'hC);
  wire y_w = mo_w & (cal.year == 7'h63);
  // Each unit carries into the next on overflow
  assign next_tm.hsec = hs_w ? 7'h00 : tm.hsec + 7'h01;
  assign next_tm.sec = s_w ? 6'h00 : (hs_w ? tm.sec + 6'h01 : tm.sec);
  assign next_tm.min = m_w ? 6'h00 : (s_w ? tm.min + 6'h01 : tm.min);
  assign next_tm.hour = h_w ? 5'h00 : (m_w ? tm.hour + 5'h01 : tm.hour);
  assign next_cal.dow = (cal.dow == 3'h7) ? 3'h1 : cal.dow + 3'h1;
  assign next_cal.date = d_w ? 5'h01 : cal.date + 5'h01;
  assign next_cal.month = mo_w ? 4'h1 : (d_w ? cal.month + 4'h1 : cal.month);
  assign next_cal.year = y_w ? 7'h00 : (mo_w ? cal.year + 7'h01 : cal.year);
  // After 2999 the count wraps to 1900
  assign next_cal.century = !y_w ? cal.century
    : (cal.century == 5'h1D ? 5'h13 : cal.century + 5'h01);

  wire keep_clr = sw_reset_i & ~keep;
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tm <= '0;
      cal <= {`CCET_CENT_RST, 7'h00, 4'h1, 5'h01, 3'h1};
    end
    else if (keep_clr)
    begin
      tm <= '0;
      cal <= {`CCET_CENT_RST, 7'h00, 4'h1, 5'h01, 3'h1};
    end
    else
    begin
      if (wr_time)
        tm <= w_tm;
      else if (t_run)
        tm <= next_tm;
      if (wr_cal)
        cal <= w_cal;
      else if (c_run)
        cal <= next_cal;
    end
  end
  hsec_step_a: assert property (t_run && !hs_w && !wr_time && !sw_reset_i
    |=> tm.hsec == $past(tm.hsec) + 7'h01) else $error("hundredths missed tick");
  time_hold_a: assert property (time_dis && !wr_time && !sw_reset_i
    |=> tm == $past(tm)) else $error("time moved while disabled");
  cal_hold_a: assert property (cal_dis && !wr_cal && !sw_reset_i
    |=> cal == $past(cal)) else $error("calendar moved while disabled");
  hour_range_a: assert property (tm.hour <= 5'h17) else $error("hour out of range");

  // ----------------------------------------
  // Alarm and events
  // ----------------------------------------
  // Compare one cycle after the step so the new time is seen
  wire [5:0] alm_eq = {cal.month == alm_c.month, cal.date == alm_c.date,
    tm.hour == alm_t.hour, tm.min == alm_t.min, tm.sec == alm_t.sec,
    tm.hsec == alm_t.hsec};
  wire alarm_hit = chk & (|alm_en) & (&(~alm_en | alm_eq));
  wire [7:0] ev = {alarm_hit, c_run & d_w, c_run & (cal.dow == 3'h7), c_run,
    t_run & (half_w | h_w), t_run & m_w, t_run & s_w, t_run & hs_w};
  // Hardware set wins over the read-clear in the same cycle
  wire [7:0] next_flags = (flags & ~flag_clr) | (ev & flag_en);

  // ----------------------------------------
  // Wake counter
  // ----------------------------------------
  wire wake_step = tick & wake_en;
  wire wake_hit = wake_step & (wake_cnt == WAKE_W'(1));
  wire next_wake = wake_hit | (wake_o & ~rd_wclr);

  // ----------------------------------------
  // Control registers and sticky state
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      {time_dis, cal_dis} <= `CCET_CTRL_RST;
      {hour12, keep, div_en, recur, chk, wake_en} <= 6'h00;
      {alm_en, int_mask, flag_en, flags} <= 30'h0;
      alm_t <= '0;
      alm_c <= '0;
      div_int <= `CCET_DIV_INT_RST;
      div_frac <= `CCET_DIV_FRAC_RST;
      div_den <= `CCET_DENOM_RST;
      wake_per <= WAKE_W'(`CCET_WAKE_PER_RST);
      wake_cnt <= '0;
      {wake_o, wake_irq_o, rtc_irq_o} <= 3'h0;
    end
    else if (sw_reset_i)
    begin
      {time_dis, cal_dis} <= `CCET_CTRL_RST;
      {hour12, div_en, recur, chk, wake_en} <= 5'h00;
      {alm_en, int_mask, flag_en, flags} <= 30'h0;
      wake_cnt <= '0;
      {wake_o, wake_irq_o, rtc_irq_o} <= 3'h0;
      keep <= keep;
    end
    else
    begin
      chk <= t_run;
      flags <= next_flags;
      rtc_irq_o <= |(flags & int_mask);
      wake_o <= next_wake;
      wake_irq_o <= next_wake;
      if (!wake_en)
        wake_cnt <= wake_per;
      else if (wake_step)
        wake_cnt <= (wake_cnt == '0) ? wake_per : wake_cnt - WAKE_W'(1);
      if (alarm_hit && !recur)
        alm_en <= 6'h00;
      if (wr)
      begin
        case (paddr_i)
          `CCET_CTRL: {cal_dis, time_dis} <= pwdata_i[1:0];
          `CCET_HOUR_MODE: hour12 <= pwdata_i[0];
          `CCET_ALM_TIME: alm_t <= w_tm;
          `CCET_ALM_CAL: alm_c <= {12'h0, pwdata_i[`CCET_MONTH_LSB+:4],
            pwdata_i[`CCET_DATE_LSB+:5], 3'h0};
          `CCET_ALM_EN: {recur, alm_en} <= pwdata_i[`CCET_RECUR_BIT:0];
          `CCET_INT_EN: int_mask <= int_mask | pwdata_i[7:0];
          `CCET_INT_DIS: int_mask <= int_mask & ~pwdata_i[7:0];
          `CCET_FLAG_EN: flag_en <= pwdata_i[7:0];
          `CCET_KEEP: keep <= pwdata_i[0];
          `CCET_TICK_DIV:
          begin
            div_int <= pwdata_i[9:0];
            div_frac <= pwdata_i[`CCET_FRAC_LSB+:10];
            div_en <= pwdata_i[`CCET_DIV_EN_BIT];
          end
          `CCET_DENOM: div_den <= pwdata_i[9:0];
          `CCET_WAKE_PER: wake_per <= pwdata_i[WAKE_W-1:0];
          `CCET_WAKE_CTRL: wake_en <= pwdata_i[0];
          default: chk <= t_run;
        endcase
      end
    end
  end
  irq_follow_a: assert property (|(flags & int_mask) && !sw_reset_i
    |=> rtc_irq_o) else $error("masked-in flag gave no interrupt");
  oneshot_a: assert property (alarm_hit && !recur && !sw_reset_i
    |=> alm_en == 6'h00) else $error("single-shot alarm stayed armed");
  flag_set_a: assert property (ev[`CCET_EV_ALARM] && flag_en[`CCET_EV_ALARM] && !sw_reset_i
    |=> flags[`CCET_EV_ALARM]) else $error("alarm flag not recorded");
  wake_zero_a: assert property (wake_hit && !sw_reset_i
    |=> wake_o && wake_irq_o && wake_cnt == '0) else $error("wake missed at zero");
  wake_clr_a: assert property (rd_wclr && !wake_hit && !sw_reset_i
    |=> !wake_o) else $error("wake not cleared by read");
  wake_reload_a: assert property (wake_step && wake_cnt == '0 && !sw_reset_i
    |=> wake_cnt == $past(wake_per)) else $error("wake counter not reloaded");
endmodule

// ### tb/ccet_far_end.sv
// Far-side model: low-power clock source and power controller wake tally
`timescale 1ns/1ps
module ccet_far_end (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Wake line from the clock block
  input wire logic wake_i,
  // Slow clock and wake count
  output logic lp_clk_o,
  output logic [7:0] wake_cnt_o
);
  logic wake_q;
  // Free-running slow clock, phase unrelated to the system clock
  initial
  begin
    lp_clk_o = 1'b0;
    #37;
    forever #100 lp_clk_o = ~lp_clk_o;
  end
  // Counts each new wake request, as an edge-sensitive controller would latch it
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wake_q <= 1'b0;
      wake_cnt_o <= 8'h00;
    end
    else
    begin
      wake_q <= wake_i;
      if (wake_i && !wake_q)
        wake_cnt_o <= wake_cnt_o + 8'h01;
    end
  end
endmodule

// ### tb/ccet_top_tb.sv
// Self-checking bench for the calendar clock with wake counter
`timescale 1ns/1ps
`include "ccet_defs.svh"
module ccet_top_tb;
  logic clk_sys_i;
  logic reset_n_i;
  logic sw_reset_i;
  logic lp_clk;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rtc_irq;
  logic wake;
  logic wake_irq;
  logic [7:0] wake_cnt;
  logic [33:0] note_q[$];
  logic [33:0] note;
  logic [31:0] v;
  int num_errors;
  int n_tests;
  int seed;
  int i;

  ccet_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sw_reset_i(sw_reset_i),
    .lp_clk_i(lp_clk), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rtc_irq_o(rtc_irq), .wake_o(wake), .wake_irq_o(wake_irq));
  ccet_far_end far_end (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wake_i(wake),
    .lp_clk_o(lp_clk), .wake_cnt_o(wake_cnt));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task summarize();
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  function int rnd(input int n);
    rnd = ($random(seed) & 32'h7FFFFFFF) % n;
  endfunction

  function logic [31:0] tval(input int h, input int m, input int s, input int hs);
    tval = (32'(h) << `CCET_HOUR_LSB) | (32'(m) << `CCET_MIN_LSB) |
      (32'(s) << `CCET_SEC_LSB) | 32'(hs);
  endfunction

  function logic [31:0] cval(input int c, input int y, input int mo, input int d, input int w);
    cval = (32'(c) << `CCET_CENT_LSB) | (32'(y) << `CCET_YEAR_LSB) |
      (32'(mo) << `CCET_MONTH_LSB) | (32'(d) << `CCET_DATE_LSB) | 32'(w);
  endfunction

  // One APB transfer; the note is queued before the setup cycle starts
  task apb(input logic [7:0] a, input logic w, input logic [31:0] dat, input logic err);
    int k;
    note_q.push_back({~w, err, dat});
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= w ? dat : 32'h00000000;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    k = 0;
    // Access ends at the rising edge where pready is seen high; release right after it
    @(posedge clk_sys_i);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k == 50)
    begin
      num_errors++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for rtc_irq (0) or wake (1), giving up after a bounded count
  task wait_for(input int which);
    int k;
    k = 0;
    @(negedge clk_sys_i);
    while (((which == 0) ? rtc_irq : wake) !== 1'b1 && k < 20000)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k == 20000)
    begin
      num_errors++;
      summarize();
    end
  endtask

  task sw_pulse();
    @(posedge clk_sys_i);
    sw_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_reset_i <= 1'b0;
  endtask

  // Access phase as sampled at its closing rising edge, compared against the oldest note
  always @(posedge clk_sys_i)
  begin
    if (psel && penable && pready)
    begin
      note = note_q.pop_front();
      check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
      if (note[33])
        check("prdata", note[31:0], prdata);
    end
  end

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 53321;
    reset_n_i = 1'b0;
    sw_reset_i = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    apb(`CCET_CTRL, 0, 32'h00000003, 0);
    apb(`CCET_CAL, 0, cval(20, 0, 1, 1, 1), 0);
    apb(`CCET_TICK_DIV, 0, {6'h00, 10'h2A8, 6'h00, 10'h147}, 0);
    apb(`CCET_DENOM, 0, 32'h000003E8, 0);
    apb(`CCET_WAKE_PER, 0, 32'h00000064, 0);
    apb(8'h48, 0, 32'h00000000, 1); // unmapped
    // Random legal settings read back as written, then the field boundaries checked by pslverr
    for (i = 0; i < 3; i++)
    begin
      v = tval(rnd(24), rnd(60), rnd(60), rnd(100));
      apb(`CCET_TIME, 1, v, 0);
      apb(`CCET_TIME, 0, v, 0);
      v = cval(19 + rnd(11), rnd(100), 1 + rnd(12), 1 + rnd(28), 1 + rnd(7));
      apb(`CCET_CAL, 1, v, 0);
      apb(`CCET_CAL, 0, v, 0);
    end
    apb(`CCET_CAL, 1, cval(29, 99, 12, 31, 7), 0);
    apb(`CCET_CAL, 1, cval(30, 0, 1, 1, 1), 1);
    apb(`CCET_CAL, 1, cval(20, 0, 13, 1, 1), 1);
    apb(`CCET_TIME, 1, tval(24, 0, 0, 0), 1);
    apb(`CCET_TIME, 1, tval(0, 60, 0, 0), 1);
    apb(`CCET_WAKE_CNT, 1, 32'h00000005, 0);
    // Leap-day midnight: every field up to week rolls over on one tick
    apb(`CCET_TIME, 1, tval(23, 59, 59, 99), 0);
    apb(`CCET_CAL, 1, cval(20, 24, 2, 28, 7), 0);
    apb(`CCET_FLAG_EN, 1, 32'h000000FF, 0);
    apb(`CCET_INT_EN, 1, 32'h000000FF, 0);
    apb(`CCET_TICK_DIV, 1, 32'h80000002, 0);
    apb(`CCET_CTRL, 1, 32'h00000000, 0);
    wait_for(0);
    apb(`CCET_CAL, 0, cval(20, 24, 2, 29, 1), 0);
    apb(`CCET_FLAGS, 0, 32'h0000003F, 0);
    apb(`CCET_FLAGS, 0, 32'h00000000, 0);
    apb(`CCET_INT_DIS, 1, 32'h0000007F, 0);
    apb(`CCET_INT_EN, 0, 32'h00000080, 0);
    // Single-shot alarm on the seconds field only
    apb(`CCET_ALM_TIME, 1, tval(0, 0, 1, 0), 0);
    apb(`CCET_ALM_EN, 1, 32'h00000002, 0);
    wait_for(0);
    apb(`CCET_FLAGS, 0, 32'h00000081, 0);
    apb(`CCET_ALM_EN, 0, 32'h00000000, 0);
    // Recurring alarm on the same second stays armed after it fires
    apb(`CCET_ALM_EN, 1, 32'h00000042, 0);
    wait_for(0);
    apb(`CCET_ALM_EN, 0, 32'h00000042, 0);
    apb(`CCET_ALM_EN, 1, 32'h00000000, 0);
    // Wake counter: fire, clear by read, reload and fire again
    apb(`CCET_WAKE_PER, 1, 32'h00000003, 0);
    apb(`CCET_WAKE_CTRL, 1, 32'h00000001, 0);
    for (i = 0; i < 2; i++)
    begin
      wait_for(1);
      check("wake_irq", 32'h00000001, {31'h0, wake_irq});
      apb(`CCET_WAKE_CLR, 0, 32'h00000000, 0);
      repeat (2) @(negedge clk_sys_i);
      check("wake", 32'h00000000, {31'h0, wake});
    end
    apb(`CCET_WAKE_CTRL, 1, 32'h00000000, 0);
    apb(`CCET_WAKE_CNT, 0, 32'h00000003, 0);
    check("wake count", 32'h00000002, {24'h0, wake_cnt});
    // Software reset with and without the keep setting
    apb(`CCET_CTRL, 1, 32'h00000003, 0);
    apb(`CCET_KEEP, 1, 32'h00000001, 0);
    sw_pulse();
    apb(`CCET_CAL, 0, cval(20, 24, 2, 29, 1), 0);
    apb(`CCET_KEEP, 1, 32'h00000000, 0);
    sw_pulse();
    apb(`CCET_CAL, 0, cval(20, 0, 1, 1, 1), 0);
    // Stopped time holds; calendar stays put across a day carry
    apb(`CCET_TICK_DIV, 1, 32'h80000002, 0);
    apb(`CCET_TIME, 1, tval(1, 2, 3, 4), 0);
    repeat (200) @(posedge clk_sys_i);
    apb(`CCET_TIME, 0, tval(1, 2, 3, 4), 0);
    apb(`CCET_TIME, 1, tval(23, 59, 59, 99), 0);
    apb(`CCET_CTRL, 1, 32'h00000002, 0);
    repeat (200) @(posedge clk_sys_i);
    apb(`CCET_CAL, 0, cval(20, 0, 1, 1, 1), 0);
    // Twelve-hour presentation
    apb(`CCET_CTRL, 1, 32'h00000003, 0);
    apb(`CCET_HOUR_MODE, 1, 32'h00000001, 0);
    v = tval(12, 0, 0, 0) | (32'h1 << `CCET_PM_BIT);
    apb(`CCET_TIME, 1, v, 0);
    apb(`CCET_TIME, 0, v, 0);
    apb(`CCET_TIME, 1, tval(13, 0, 0, 0), 1);
    apb(`CCET_TIME, 1, tval(0, 0, 0, 0), 1);
    repeat (2) @(posedge clk_sys_i);
    summarize();
  end
endmodule
